// ==== rtl/rac_pkg.sv ====
package rac_pkg;

    // ------------------------------------------------------------------
    // register map (byte offsets on the local access port)
    // ------------------------------------------------------------------
    localparam int          ADDR_W       = 6;
    localparam int          DATA_W       = 32;
    localparam int          FLAG_W       = 8;
    localparam logic [5:0]  OFS_CTRL     = 6'h00;
    localparam logic [5:0]  OFS_STATUS   = 6'h04;
    localparam logic [5:0]  OFS_KEY      = 6'h08;
    localparam logic [5:0]  OFS_DBGCTRL  = 6'h0C;
    localparam logic [5:0]  OFS_FLAGCLR  = 6'h10;
    localparam logic [5:0]  OFS_FLAGSET  = 6'h14;

    // ------------------------------------------------------------------
    // field layout, masks and reset values
    // ------------------------------------------------------------------
    localparam int           CTRL_SWRST_BIT = 0;
    localparam logic [31:0]  CTRL_RW_MASK   = 32'h0000_00F2;
    localparam logic [31:0]  CTRL_RST       = 32'h0000_0010;
    localparam logic [31:0]  STATUS_MASK    = 32'h0000_00FF;
    localparam logic [31:0]  KEY_RST        = 32'h0000_0000;
    localparam logic [31:0]  DBG_RW_MASK    = 32'h0000_0001;
    localparam logic [31:0]  DBG_RST        = 32'h0000_0000;
    localparam logic [7:0]   FLAG_RST       = 8'h00;

    // ------------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic              wrEn;
        logic              rdEn;
        logic [5:0]        addr;
        logic [31:0]       wdata;
    } rac_access_t;

    typedef struct packed {
        logic              setEn;
        logic [7:0]        setMask;
        logic              clrEn;
        logic [7:0]        clrMask;
    } rac_pair_t;

endpackage

// ==== rtl/rac_register_bank.sv ====
`timescale 1ns/1ps
// Summary of operation
// R1 - read/write bits return last written value
// R2 - read-only bits ignore writes
// R3 - write-only bits read back undefined
// R4 - reserved bits always read zero
// R5 - software writes reserved bits as zero
// R6 - reset values restored; soft reset spares debug
// R7 - set/clear writes change both views
// R8 - set and clear views read identical
// R9 - simultaneous set and clear: clear wins
// R10 - writing zero to set/clear changes nothing
module rac_register_bank
    import rac_pkg::*;
(
    input  wire logic               clk,          // 125 MHz clock
    input  wire logic               nrst,         // async reset, active low
    input  wire rac_access_t        acc,          // addressed read/write port
    input  wire rac_pair_t          pairWr,       // second writer of the set/clear pair
    input  wire logic [7:0]         hwStatus,     // block state shown in status
    output logic [31:0]             rdData,       // read data, one cycle after read
    output logic                    rdValid,      // read data valid pulse
    output logic [31:0]             ctrlOut,      // control register contents
    output logic [31:0]             keyOut,       // last key word written since the last reset
    output logic                    keyStrobe,    // pulse when key is written
    output logic [31:0]             dbgOut,       // debug control contents
    output logic [7:0]              flagsOut      // shared set/clear bits
);

    // ------------------------------------------------------------------
    // decode
    // ------------------------------------------------------------------
    logic        wrCtrl;
    logic        wrKey;
    logic        wrDbg;
    logic        wrSet;
    logic        wrClr;
    logic        softRst;
    logic [7:0]  setBits;
    logic [7:0]  clrBits;
    logic [31:0] ctrl_reg;
    logic [31:0] key_reg;
    logic [31:0] dbg_reg;
    logic [7:0]  flags_reg;
    logic [7:0]  flags_next;
    logic [31:0] rdData_reg;
    logic        rdValid_reg;
    logic        keyStrobe_reg;
    logic [31:0] readMux;

    assign wrCtrl  = acc.wrEn && (acc.addr == OFS_CTRL);
    assign wrKey   = acc.wrEn && (acc.addr == OFS_KEY);
    assign wrDbg   = acc.wrEn && (acc.addr == OFS_DBGCTRL);
    assign wrSet   = acc.wrEn && (acc.addr == OFS_FLAGSET);
    assign wrClr   = acc.wrEn && (acc.addr == OFS_FLAGCLR);
    // soft reset acts on the cycle after the write, as a single pulse
    assign softRst = ctrl_reg[CTRL_SWRST_BIT];

    // ------------------------------------------------------------------
    // control register, self-clearing soft reset bit
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ctrl_reg <= CTRL_RST;                                   // see R6
        end else if (softRst) begin
            ctrl_reg <= CTRL_RST;                                   // see R6
        end else if (wrCtrl) begin
            // writable bits and the soft reset bit stored; reserved stay zero  // see R1 see R4
            ctrl_reg <= (acc.wdata & (CTRL_RW_MASK | 32'h0000_0001));
        end
    end

    // ------------------------------------------------------------------
    // write-only key word: readable inside the block, not by software
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            key_reg       <= KEY_RST;
            keyStrobe_reg <= 1'b0;
        end else if (softRst) begin
            key_reg       <= KEY_RST;                               // see R6
            keyStrobe_reg <= 1'b0;
        end else begin
            keyStrobe_reg <= wrKey;
            if (wrKey) begin
                key_reg <= acc.wdata;                               // see R3
            end
        end
    end

    // ------------------------------------------------------------------
    // debug control: power reset only, soft reset leaves it alone
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            dbg_reg <= DBG_RST;                                     // see R6
        end else if (wrDbg) begin
            dbg_reg <= acc.wdata & DBG_RW_MASK;                     // see R1 see R4
        end
    end

    // ------------------------------------------------------------------
    // set/clear pair: no read-modify-write, clear taken last so it wins
    // ------------------------------------------------------------------
    always_comb begin
        setBits = (wrSet ? acc.wdata[7:0] : 8'h00)
                | (pairWr.setEn ? pairWr.setMask : 8'h00);
        clrBits = (wrClr ? acc.wdata[7:0] : 8'h00)
                | (pairWr.clrEn ? pairWr.clrMask : 8'h00);
        // zero bits leave state alone; clear overrides set  // see R7 see R9 see R10
        flags_next = (flags_reg | setBits) & ~clrBits;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            flags_reg <= FLAG_RST;                                  // see R6
        end else if (softRst) begin
            flags_reg <= FLAG_RST;                                  // see R6
        end else begin
            flags_reg <= flags_next;                                // see R7
        end
    end

    // ------------------------------------------------------------------
    // read mux; status is read-only, key reads zero, unmapped reads zero
    // ------------------------------------------------------------------
    always_comb begin
        case (acc.addr)
            OFS_CTRL:    readMux = ctrl_reg & CTRL_RW_MASK;        // see R1 see R4
            OFS_STATUS:  readMux = {24'h000000, hwStatus} & STATUS_MASK; // see R2
            OFS_KEY:     readMux = 32'h0000_0000;                   // see R3
            OFS_DBGCTRL: readMux = dbg_reg;                         // see R4
            OFS_FLAGCLR: readMux = {24'h000000, flags_reg};         // see R8
            OFS_FLAGSET: readMux = {24'h000000, flags_reg};         // see R8
            default:     readMux = 32'h0000_0000;
        endcase
    end

    // registered read answer, fixed one-cycle latency
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rdData_reg  <= 32'h0000_0000;
            rdValid_reg <= 1'b0;
        end else begin
            rdValid_reg <= acc.rdEn;
            if (acc.rdEn) begin
                rdData_reg <= readMux;
            end
        end
    end

    assign rdData    = rdData_reg;
    assign rdValid   = rdValid_reg;
    assign ctrlOut   = ctrl_reg & CTRL_RW_MASK;
    assign keyOut    = key_reg;
    assign keyStrobe = keyStrobe_reg;
    assign dbgOut    = dbg_reg;
    assign flagsOut  = flags_reg;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    // a write during the soft reset pulse is lost, so it cannot be read back
    sequence ctrlWritePlain;
        wrCtrl && !acc.wdata[CTRL_SWRST_BIT] && !softRst;
    endsequence

    sequence readCtrlNext;
        !acc.wrEn && acc.rdEn && acc.addr == OFS_CTRL;
    endsequence

    chk_rw_readback: assert property (                              // see R1
        ctrlWritePlain ##1 readCtrlNext |=>
            rdData == ($past(acc.wdata, 2) & CTRL_RW_MASK))
        else $error("control read did not return written value");

    chk_ro_status: assert property (                                // see R2
        acc.rdEn && acc.addr == OFS_STATUS |=>
            rdData == {24'h000000, $past(hwStatus)})
        else $error("status read wrong");

    chk_wo_capture: assert property (                               // see R3
        wrKey && !softRst |=> keyOut == $past(acc.wdata) && keyStrobe)
        else $error("key write not captured");

    chk_reserved_zero: assert property (                            // see R4
        acc.rdEn && acc.addr == OFS_CTRL |=> (rdData & ~CTRL_RW_MASK) == 32'h0)
        else $error("reserved control bits read nonzero");

    chk_soft_reset: assert property (                               // see R6
        softRst && !wrDbg |=> ctrlOut == (CTRL_RST & CTRL_RW_MASK)
            && flagsOut == FLAG_RST && dbgOut == $past(dbgOut))
        else $error("soft reset values wrong");

    chk_set_clear: assert property (                                // see R7
        !softRst |=> flagsOut == (($past(flagsOut) | $past(setBits)) & ~$past(clrBits)))
        else $error("set/clear update wrong");

    chk_both_views: assert property (                               // see R8
        acc.rdEn && (acc.addr == OFS_FLAGSET || acc.addr == OFS_FLAGCLR)
            |=> rdData[7:0] == $past(flagsOut))
        else $error("pair views differ");

    chk_clear_wins: assert property (                               // see R9
        (|(setBits & clrBits)) && !softRst |=>
            (flagsOut & $past(setBits & clrBits)) == 8'h00)
        else $error("set beat clear");

    chk_zero_noop: assert property (                                // see R10
        setBits == 8'h00 && clrBits == 8'h00 && !softRst |=> $stable(flagsOut))
        else $error("flags changed without a one written");

endmodule // rac_register_bank

// ==== testbench/test_rac_register_bank.sv ====
`timescale 1ns/1ps
module test_rac_register_bank import rac_pkg::*;;
    logic        clk, nrst;          // clock and reset
    rac_access_t acc;                // register port
    rac_pair_t   pairWr;             // second set/clear writer
    logic [7:0]  hwStatus;           // status source
    logic [31:0] rdData, ctrlOut, keyOut, dbgOut;
    logic        rdValid, keyStrobe;
    logic [7:0]  flagsOut;
    int          miscompares, numChecks;

    rac_register_bank u_rac_register_bank (.clk(clk), .nrst(nrst), .acc(acc), .pairWr(pairWr),
        .hwStatus(hwStatus), .rdData(rdData), .rdValid(rdValid), .ctrlOut(ctrlOut),
        .keyOut(keyOut), .keyStrobe(keyStrobe), .dbgOut(dbgOut), .flagsOut(flagsOut));

    // ----------------------------------------------------------------
    // clock, compare and bus tasks
    // ----------------------------------------------------------------
    always #4 clk = ~clk;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        numChecks++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    // one write cycle; returns just after the edge that takes it
    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        @(posedge clk);
        acc <= '{1'b1, 1'b0, a, d};
        @(posedge clk);
        acc <= '0;
        #1;
    endtask

    // rdValid stands one cycle only, so it is looked at right after the answer edge
    task automatic rdChk(input logic [5:0] a, input logic [31:0] exp);
        @(posedge clk);
        acc <= '{1'b0, 1'b1, a, 32'h0};
        @(posedge clk);
        acc <= '0;
        #1;
        check({31'h0, rdValid}, 32'h1, "read valid");
        check(rdData, exp, "read data");
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", numChecks, miscompares);
        if (miscompares == 0 && numChecks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic testRw();
        wr(OFS_CTRL, 32'hFFFF_FFFE);
        check(ctrlOut, 32'h0000_00F2, "ctrl masked");
        rdChk(OFS_CTRL, 32'h0000_00F2);
        wr(OFS_CTRL, 32'h0000_0020);
        rdChk(OFS_CTRL, 32'h0000_0020);
        // write then read on the very next edge, reserved bits kept zero
        @(posedge clk);
        acc <= '{1'b1, 1'b0, OFS_CTRL, 32'h0000_00C2};
        @(posedge clk);
        acc <= '{1'b0, 1'b1, OFS_CTRL, 32'h0};
        @(posedge clk);
        acc <= '0;
        #1;
        check(rdData, 32'h0000_00C2, "back to back read");
        wr(OFS_DBGCTRL, 32'hFFFF_FFFF);
        rdChk(OFS_DBGCTRL, 32'h0000_0001);
        $display("done rw");
    endtask

    task automatic testRoKey();
        @(posedge clk);
        hwStatus <= 8'hA5;
        wr(OFS_STATUS, 32'h0000_005A);
        rdChk(OFS_STATUS, 32'h0000_00A5);
        wr(6'h3C, 32'hFFFF_FFFF);
        rdChk(6'h3C, 32'h0);
        // key readback is undefined, so only its outputs are judged
        wr(OFS_KEY, 32'h1234_5678);
        check({31'h0, keyStrobe}, 32'h1, "key strobe");
        check(keyOut, 32'h1234_5678, "key word");
        $display("done ro key");
    endtask

    task automatic testFlags();
        wr(OFS_FLAGSET, 32'h0000_000F);
        rdChk(OFS_FLAGSET, 32'h0000_000F);
        rdChk(OFS_FLAGCLR, 32'h0000_000F);
        wr(OFS_FLAGCLR, 32'h0000_0003);
        check({24'h0, flagsOut}, 32'h0000_000C, "clear");
        wr(OFS_FLAGSET, 32'h0);
        wr(OFS_FLAGCLR, 32'h0);
        check({24'h0, flagsOut}, 32'h0000_000C, "zero writes");
        @(posedge clk);
        acc <= '{1'b1, 1'b0, OFS_FLAGSET, 32'h0000_0031};
        pairWr <= '{1'b1, 8'h40, 1'b1, 8'h11};
        @(posedge clk);
        acc <= '0;
        pairWr <= '{1'b1, 8'h80, 1'b1, 8'h80};
        @(posedge clk);
        pairWr <= '0;
        #1;
        check({24'h0, flagsOut}, 32'h0000_006C, "clear wins");
        $display("done flags");
    endtask

    task automatic testSoftReset();
        wr(OFS_DBGCTRL, 32'h1);
        wr(OFS_CTRL, 32'h0000_00F3);
        @(posedge clk);
        #1;
        check(ctrlOut, CTRL_RST, "soft ctrl");
        check(keyOut, KEY_RST, "soft key");
        check({24'h0, flagsOut}, 32'h0, "soft flags");
        check(dbgOut, 32'h1, "debug kept");
        rdChk(OFS_CTRL, CTRL_RST);
        @(posedge clk);
        nrst <= 1'b0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        #1;
        check(dbgOut, DBG_RST, "power debug");
        $display("done soft reset");
    endtask

    // ----------------------------------------------------------------
    // main sequence and watchdog
    // ----------------------------------------------------------------
    initial begin
        clk = 1'b0;
        nrst = 1'b0;
        acc = '0;
        pairWr = '0;
        hwStatus = 8'h00;
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        #1;
        check(ctrlOut, CTRL_RST, "reset ctrl");
        check({24'h0, flagsOut}, 32'h0, "reset flags");
        testRw();
        testRoKey();
        testFlags();
        testSoftReset();
        summarize();
    end

    // the tests take about 60 cycles; this limit leaves ample room
    initial begin
        repeat (2000) @(posedge clk);
        miscompares++;
        summarize();
    end
endmodule // test_rac_register_bank
